/* File: core/i2cs_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cs_slave #(
    parameter int FILTER_CYCLES = i2cs_pkg::DEGLITCH_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // bus pins, enables low while driving
    input  wire logic       scl_in,
    output logic            scl_out_reg,
    output logic            scl_oe_n_reg,
    input  wire logic       sda_in,
    output logic            sda_out_reg,
    output logic            sda_oe_n_reg,
    // supply monitors, from analog comparators
    input  wire logic       interface_supply_below,
    input  wire logic       system_supply_below,
    // configuration
    input  wire logic [1:0] addr_option,
    input  wire logic       test_unlocked,
    // register write stream
    output logic            wr_valid_reg,
    output logic [7:0]      wr_ptr_reg,
    output logic [7:0]      wr_data_reg,
    input  wire logic       wr_ready,
    // register read port
    output logic [7:0]      rd_ptr_reg,
    input  wire logic [7:0] rd_data
);

    ////////////////////////////////////////////////////////////////////////////
    // pin conditioning

    logic scl_f;
    logic sda_f;
    logic ifs_low_f;
    logic sys_low_f;
    logic scl_d_reg;
    logic sda_d_reg;

    i2cs_filter #(.STABLE_CYCLES(FILTER_CYCLES), .RESET_LEVEL(i2cs_pkg::LINE_IDLE)) u_scl_flt (
        .clk       (clk),
        .rst       (rst),
        .raw       (scl_in),
        .level_reg (scl_f)
    );

    i2cs_filter #(.STABLE_CYCLES(FILTER_CYCLES), .RESET_LEVEL(i2cs_pkg::LINE_IDLE)) u_sda_flt (
        .clk       (clk),
        .rst       (rst),
        .raw       (sda_in),
        .level_reg (sda_f)
    );

    i2cs_filter #(.STABLE_CYCLES(FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_ifs_flt (
        .clk       (clk),
        .rst       (rst),
        .raw       (interface_supply_below),
        .level_reg (ifs_low_f)
    );

    i2cs_filter #(.STABLE_CYCLES(FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_sys_flt (
        .clk       (clk),
        .rst       (rst),
        .raw       (system_supply_below),
        .level_reg (sys_low_f)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_d_reg <= i2cs_pkg::LINE_IDLE;
            sda_d_reg <= i2cs_pkg::LINE_IDLE;
        end else begin
            scl_d_reg <= scl_f;
            sda_d_reg <= sda_f;
        end
    end

    logic bus_off;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign bus_off    = ifs_low_f & sys_low_f;
    assign scl_rise   = scl_f & ~scl_d_reg;
    assign scl_fall   = ~scl_f & scl_d_reg;
    // data edges seen only while the clock stays high are conditions
    assign start_cond = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
    assign stop_cond  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

    ////////////////////////////////////////////////////////////////////////////
    // address option, caught once after reset

    logic [1:0] addr_opt_reg;
    logic       opt_taken_reg;
    logic [6:0] main_addr;

    always_ff @(posedge clk) begin
        if (rst) begin
            opt_taken_reg <= 1'b0;
            addr_opt_reg  <= 2'h0;
        end else if (!opt_taken_reg) begin
            opt_taken_reg <= 1'b1;
            addr_opt_reg  <= addr_option;
        end
    end

    always_comb begin
        unique case (addr_opt_reg)
            2'h0: main_addr = i2cs_pkg::MAIN_ADDR_OPT0;
            2'h1: main_addr = i2cs_pkg::MAIN_ADDR_OPT1;
            2'h2: main_addr = i2cs_pkg::MAIN_ADDR_OPT2;
            2'h3: main_addr = i2cs_pkg::MAIN_ADDR_OPT3;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit framing

    i2cs_pkg::i2cs_state_e state_reg;
    logic [3:0]            bit_cnt_reg;
    logic [7:0]            rx_reg;
    logic [7:0]            tx_reg;
    logic                  ack_reg;
    logic                  mnack_reg;
    logic                  in_ack;
    logic                  addr_hit;
    logic                  ack_next;
    logic                  buf_in_ready;

    assign in_ack = (bit_cnt_reg == i2cs_pkg::ACK_SLOT);

    // general call can never equal a main or test address; kept explicit
    assign addr_hit = (rx_reg[7:1] != i2cs_pkg::GENERAL_CALL)
                    & ((rx_reg[7:1] == main_addr)
                    | (test_unlocked & (rx_reg[7:1] == i2cs_pkg::TEST_ADDR)));

    always_comb begin
        unique case (state_reg)
            i2cs_pkg::ST_ADDR:  ack_next = addr_hit;
            i2cs_pkg::ST_PTR:   ack_next = 1'b1;
            // no clock stretching, so a full buffer can only refuse the byte
            i2cs_pkg::ST_WDATA: ack_next = buf_in_ready;
            default:            ack_next = 1'b0;
        endcase
    end

    // sample on rising edge, count on falling edge
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_reg    <= 8'h00;
            mnack_reg <= 1'b1;
        end else if (scl_rise) begin
            if (!in_ack)
                rx_reg <= {rx_reg[6:0], sda_f};
            else
                mnack_reg <= sda_f;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || bus_off) begin
            state_reg   <= i2cs_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            ack_reg     <= 1'b0;
        end else if (start_cond) begin
            state_reg   <= i2cs_pkg::ST_ADDR;
            // the clock fall that closes the start is no bit: it wraps this to zero
            bit_cnt_reg <= 4'hF;
        end else if (stop_cond) begin
            state_reg   <= i2cs_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (scl_fall && state_reg != i2cs_pkg::ST_IDLE) begin
            if (bit_cnt_reg == i2cs_pkg::LAST_DATA_BIT) begin
                bit_cnt_reg <= i2cs_pkg::ACK_SLOT;
                ack_reg     <= ack_next;
            end else if (in_ack) begin
                bit_cnt_reg <= 4'h0;
                unique case (state_reg)
                    i2cs_pkg::ST_ADDR:
                        if (!ack_reg)
                            state_reg <= i2cs_pkg::ST_IGNORE;
                        else if (rx_reg[0])
                            state_reg <= i2cs_pkg::ST_RDATA;
                        else
                            state_reg <= i2cs_pkg::ST_PTR;
                    i2cs_pkg::ST_PTR:
                        state_reg <= i2cs_pkg::ST_WDATA;
                    i2cs_pkg::ST_RDATA:
                        if (mnack_reg)
                            state_reg <= i2cs_pkg::ST_IGNORE;
                    default:
                        state_reg <= state_reg;
                endcase
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register pointer, kept over STOP and supply loss

    logic last_fall;
    assign last_fall = scl_fall & (bit_cnt_reg == i2cs_pkg::LAST_DATA_BIT);

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr_reg <= i2cs_pkg::PTR_RESET;
        end else if (last_fall && state_reg == i2cs_pkg::ST_PTR) begin
            rd_ptr_reg <= rx_reg;
        end else if (last_fall && state_reg == i2cs_pkg::ST_WDATA && buf_in_ready) begin
            rd_ptr_reg <= rd_ptr_reg + 8'h01;
        end else if (scl_rise && in_ack && state_reg == i2cs_pkg::ST_RDATA && !sda_f) begin
            // only an acknowledged read moves on, so a re-read hits the same register
            rd_ptr_reg <= rd_ptr_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data line driver

    logic load_tx;
    assign load_tx = scl_fall & in_ack
                   & ((state_reg == i2cs_pkg::ST_ADDR & ack_reg & rx_reg[0])
                   | (state_reg == i2cs_pkg::ST_RDATA & ~mnack_reg));

    always_ff @(posedge clk) begin
        if (rst)
            tx_reg <= 8'h00;
        else if (load_tx)
            tx_reg <= rd_data;
    end

    // oe_n low pulls the line low; released means logic one
    always_ff @(posedge clk) begin
        if (rst || bus_off || start_cond || stop_cond) begin
            sda_oe_n_reg <= 1'b1;
        end else if (scl_fall) begin
            if (load_tx)
                sda_oe_n_reg <= rd_data[7];
            else if (bit_cnt_reg == i2cs_pkg::LAST_DATA_BIT)
                sda_oe_n_reg <= ~ack_next;
            else if (!in_ack && state_reg == i2cs_pkg::ST_RDATA)
                sda_oe_n_reg <= tx_reg[3'(3'd6 - bit_cnt_reg[2:0])];
            else
                sda_oe_n_reg <= 1'b1;
        end
    end

    // clock pin is never driven
    always_ff @(posedge clk) begin
        scl_oe_n_reg <= 1'b1;
        scl_out_reg  <= 1'b0;
        sda_out_reg  <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // write stream through a two-entry buffer

    logic        push_reg;
    logic [15:0] push_word_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            push_reg      <= 1'b0;
            push_word_reg <= 16'h0000;
        end else begin
            push_reg <= last_fall & (state_reg == i2cs_pkg::ST_WDATA) & buf_in_ready
                      & ~bus_off;
            if (last_fall)
                push_word_reg <= {rd_ptr_reg, rx_reg};
        end
    end

    i2cs_buf2 #(.WIDTH(16)) u_wbuf (
        .clk           (clk),
        .rst           (rst),
        .in_valid      (push_reg),
        .in_data       (push_word_reg),
        .in_ready      (buf_in_ready),
        .out_valid_reg (wr_valid_reg),
        .out_data_reg  ({wr_ptr_reg, wr_data_reg}),
        .out_ready     (wr_ready)
    );

endmodule : i2cs_slave
`default_nettype wire

/* File: core/i2cs_pkg.sv */
package i2cs_pkg;

    // main address per factory option value 0..3, and the test address
    localparam logic [6:0] MAIN_ADDR_OPT0 = 7'h40;
    localparam logic [6:0] MAIN_ADDR_OPT1 = 7'h48;
    localparam logic [6:0] MAIN_ADDR_OPT2 = 7'h44;
    localparam logic [6:0] MAIN_ADDR_OPT3 = 7'h4C;
    localparam logic [6:0] TEST_ADDR      = 7'h49;
    localparam logic [6:0] GENERAL_CALL   = 7'h00;

    // packet layout: eight data bits, then the acknowledge slot
    localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
    localparam logic [3:0] ACK_SLOT       = 4'h8;

    // reset values
    localparam logic [7:0] PTR_RESET      = 8'h00;
    localparam logic       LINE_IDLE      = 1'b1;

    // timing
    localparam int CLK_PERIOD_PS   = 25000;
    localparam int DEGLITCH_NS     = 50;
    localparam int DEGLITCH_CYCLES = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCL_MAX_KHZ     = 1000;
    localparam int SCL_MIN_HIGH_NS = 260;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b00_0001,
        ST_ADDR   = 6'b00_0010,
        ST_PTR    = 6'b00_0100,
        ST_WDATA  = 6'b00_1000,
        ST_RDATA  = 6'b01_0000,
        ST_IGNORE = 6'b10_0000
    } i2cs_state_e;

endpackage : i2cs_pkg

/* File: core/i2cs_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cs_filter #(
    parameter int   STABLE_CYCLES = 2,
    parameter logic RESET_LEVEL   = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // raw level from outside the clock domain
    input  wire logic raw,
    // synchronised, deglitched level
    output logic      level_reg
);

    logic       sync1_reg;
    logic       sync2_reg;
    logic [7:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= RESET_LEVEL;
            sync2_reg <= RESET_LEVEL;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
        end
    end

    // a change must hold for STABLE_CYCLES before it is passed on
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg   <= 8'h00;
            level_reg <= RESET_LEVEL;
        end else if (sync2_reg == level_reg) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg >= 8'(STABLE_CYCLES - 1)) begin
            cnt_reg   <= 8'h00;
            level_reg <= sync2_reg;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

endmodule : i2cs_filter
`default_nettype wire

/* File: core/i2cs_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cs_buf2 #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // draining side
    output logic                  out_valid_reg,
    output logic      [WIDTH-1:0] out_data_reg,
    input  wire logic             out_ready
);

    logic             tail_valid_reg;
    logic [WIDTH-1:0] tail_data_reg;
    logic             pop;
    logic             push;

    // two entries: head drives the outputs, tail catches a word during a stall
    assign in_ready = ~tail_valid_reg;
    assign pop      = out_valid_reg & out_ready;
    assign push     = in_valid & in_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid_reg  <= 1'b0;
            tail_valid_reg <= 1'b0;
        end else begin
            if (pop || !out_valid_reg) begin
                out_valid_reg  <= tail_valid_reg | push;
                tail_valid_reg <= tail_valid_reg & push;
            end else if (push) begin
                tail_valid_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_data_reg  <= '0;
            tail_data_reg <= '0;
        end else begin
            if (pop || !out_valid_reg) begin
                out_data_reg <= tail_valid_reg ? tail_data_reg : in_data;
                if (tail_valid_reg && push)
                    tail_data_reg <= in_data;
            end else if (push) begin
                tail_data_reg <= in_data;
            end
        end
    end

endmodule : i2cs_buf2
`default_nettype wire

/* File: bench/i2cs_slave_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cs_slave_assertions (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // bus pins
    input wire logic       scl_in,
    input wire logic       scl_out_reg,
    input wire logic       scl_oe_n_reg,
    input wire logic       sda_in,
    input wire logic       sda_out_reg,
    input wire logic       sda_oe_n_reg,
    // supplies, write stream and read pointer
    input wire logic       interface_supply_below,
    input wire logic       system_supply_below,
    input wire logic       wr_valid_reg,
    input wire logic [7:0] wr_ptr_reg,
    input wire logic [7:0] wr_data_reg,
    input wire logic       wr_ready,
    input wire logic [7:0] rd_ptr_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic both_low;
    logic in_frame_reg;
    assign both_low = interface_supply_below && system_supply_below;
    // framing seen at the pins, ahead of the filters
    always_ff @(posedge clk) begin
        if (rst) begin
            in_frame_reg <= 1'b0;
        end else if (scl_in && $fell(sda_in)) begin
            in_frame_reg <= 1'b1;
        end else if (scl_in && $rose(sda_in)) begin
            in_frame_reg <= 1'b0;
        end
    end
    ////////////////////////////////////////
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    sequence s_supply_off;
        both_low [*8] ##1 both_low [*8];
    endsequence
    property p_clock_input;
        scl_oe_n_reg && !scl_out_reg;
    endproperty
    property p_pull_low_only;
        !sda_oe_n_reg |-> !sda_out_reg;
    endproperty
    property p_hold_word;
        wr_valid_reg && !wr_ready |=> wr_valid_reg && $stable(wr_ptr_reg) && $stable(wr_data_reg);
    endproperty
    property p_oe_in_low;
        $changed(sda_oe_n_reg) && !both_low && !$past(both_low, 8)
            |-> !scl_in && !$past(scl_in, 4);
    endproperty
    property p_stop_release;
        s_stop |-> sda_oe_n_reg [*8];
    endproperty
    property p_idle;
        !sda_oe_n_reg |-> in_frame_reg;
    endproperty
    property p_ack_hold;
        $rose(scl_in) && !sda_oe_n_reg |-> !sda_oe_n_reg [*8];
    endproperty
    property p_push_ptr;
        $rose(wr_valid_reg) |-> rd_ptr_reg == wr_ptr_reg + 8'h01;
    endproperty
    property p_supply_off;
        s_supply_off |-> sda_oe_n_reg;
    endproperty
    a_clock_input: assert property (p_clock_input)
        else $error("clock pin driven");
    a_pull_low_only: assert property (p_pull_low_only)
        else $error("data pin driven high");
    a_hold_word: assert property (p_hold_word)
        else $error("write word changed while stalled");
    a_oe_in_low: assert property (p_oe_in_low)
        else $error("data changed with clock high");
    a_stop_release: assert property (p_stop_release)
        else $error("data held after stop");
    a_idle: assert property (p_idle)
        else $error("data driven outside a frame");
    a_ack_hold: assert property (p_ack_hold)
        else $error("low level not held through clock high");
    a_push_ptr: assert property (p_push_ptr)
        else $error("pointer not advanced with write word");
    a_supply_off: assert property (p_supply_off)
        else $error("data driven with supplies off");
endmodule : i2cs_slave_assertions
bind i2cs_slave i2cs_slave_assertions i2cs_slave_assertions_inst (
    .clk(clk), .rst(rst), .scl_in(scl_in), .scl_out_reg(scl_out_reg),
    .scl_oe_n_reg(scl_oe_n_reg), .sda_in(sda_in), .sda_out_reg(sda_out_reg),
    .sda_oe_n_reg(sda_oe_n_reg), .interface_supply_below(interface_supply_below),
    .system_supply_below(system_supply_below), .wr_valid_reg(wr_valid_reg),
    .wr_ptr_reg(wr_ptr_reg), .wr_data_reg(wr_data_reg), .wr_ready(wr_ready),
    .rd_ptr_reg(rd_ptr_reg)
);
`default_nettype wire

/* File: bench/i2cs_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cs_master_model (
    // clock
    input  wire logic clk,
    // bus, 1 = released
    output logic      scl_reg,
    output logic      sda_rel_reg,
    input  wire logic sda_line
);
    // 1 MHz, top rate the slave accepts: quarter bit is 10 clk
    task automatic q(input int n);
        repeat (n * 10) @(posedge clk);
    endtask : q
    initial begin
        scl_reg = 1'b1;
        sda_rel_reg = 1'b1;
    end
    // also a repeated start
    task automatic start();
        sda_rel_reg <= 1'b1;
        q(1);
        scl_reg <= 1'b1;
        q(1);
        sda_rel_reg <= 1'b0;
        q(2);
        scl_reg <= 1'b0;
        q(1);
    endtask : start
    task automatic stop();
        sda_rel_reg <= 1'b0;
        q(1);
        scl_reg <= 1'b1;
        q(1);
        sda_rel_reg <= 1'b1;
        q(2);
    endtask : stop
    task automatic bit_io(input logic b, output logic got);
        sda_rel_reg <= b;
        q(1);
        scl_reg <= 1'b1;
        q(1);
        got = sda_line;
        q(1);
        scl_reg <= 1'b0;
        q(1);
    endtask : bit_io
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack_out);
    endtask : xfer
endmodule : i2cs_master_model
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst, m_scl, m_sda, scl_out, scl_oe_n, sda_out, sda_oe_n;
    logic        if_low, sys_low, test_unlocked, wr_valid, wr_ready, stall;
    logic [1:0]  addr_option;
    logic [7:0]  wr_ptr, wr_data, rd_ptr, rd_data;
    logic [31:0] rng_reg = 32'h0000_fda9;
    logic [7:0]  q_ptr[$];
    logic [7:0]  q_data[$];
    int          failures;
    int          comparisons;
    wire logic   scl_line = m_scl & (scl_oe_n | scl_out);
    wire logic   sda_line = m_sda & (sda_oe_n | sda_out);

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    function automatic logic [7:0] reg_val(input logic [7:0] p);
        return {p[3:0], p[7:4]} ^ 8'h3c;
    endfunction : reg_val
    assign rd_data = reg_val(rd_ptr);

    i2cs_slave i2cs_slave_inst (
        .clk(clk), .rst(rst), .scl_in(scl_line), .scl_out_reg(scl_out),
        .scl_oe_n_reg(scl_oe_n), .sda_in(sda_line), .sda_out_reg(sda_out),
        .sda_oe_n_reg(sda_oe_n), .interface_supply_below(if_low),
        .system_supply_below(sys_low), .addr_option(addr_option),
        .test_unlocked(test_unlocked), .wr_valid_reg(wr_valid), .wr_ptr_reg(wr_ptr),
        .wr_data_reg(wr_data), .wr_ready(wr_ready), .rd_ptr_reg(rd_ptr), .rd_data(rd_data)
    );
    i2cs_master_model i2cs_master_model_inst (
        .clk(clk), .scl_reg(m_scl), .sda_rel_reg(m_sda), .sda_line(sda_line)
    );
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        rng_reg <= xs(rng_reg);
        wr_ready <= !stall && rng_reg[0];
        if (wr_valid && wr_ready) begin
            q_ptr.push_back(wr_ptr);
            q_data.push_back(wr_data);
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic check_bit(input string what, input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check_bit
    task automatic check_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_byte
    task automatic do_reset(input logic [1:0] opt);
        rst <= 1'b1;
        addr_option <= opt;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : do_reset
    task automatic addr_phase(input logic [6:0] a, input logic rw, output logic ack);
        logic [7:0] rx;
        i2cs_master_model_inst.start();
        i2cs_master_model_inst.xfer({a, rw}, 1'b1, rx, ack);
    endtask : addr_phase
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin : main
        logic       ack, unl;
        logic [7:0] rx, ptr;
        logic [7:0] dat [3];
        logic [6:0] a, own;
        logic [6:0] mains [4];
        rst = 1'b1;
        addr_option = 2'h0;
        test_unlocked = 1'b0;
        if_low = 1'b0;
        sys_low = 1'b0;
        stall = 1'b1;
        failures = 0;
        comparisons = 0;
        mains = '{7'h40, 7'h48, 7'h44, 7'h4c};
        for (int o = 0; o < 4; o++) begin
            do_reset(o[1:0]);
            addr_option <= ~o[1:0];
            check_byte("reset ptr", rd_ptr, 8'h00);
            check_bit("idle", sda_oe_n, 1'b1);
            for (int k = 0; k < 8; k++) begin
                a = (k < 4) ? mains[k] : (k < 6) ? 7'h49 : (k == 6) ? 7'h00 : rng_reg[6:0];
                unl = (k == 4) ? 1'b1 : (k == 5) ? 1'b0 : rng_reg[9];
                test_unlocked <= unl;
                addr_phase(a, 1'b0, ack);
                check_bit("addr", ack, !(a == mains[o] || (a == 7'h49 && unl)));
                i2cs_master_model_inst.stop();
            end
        end
        // stalled sink: third byte meets a full buffer
        own = mains[3];
        ptr = rng_reg[7:0];
        addr_phase(own, 1'b0, ack);
        check_bit("wr addr", ack, 1'b0);
        i2cs_master_model_inst.xfer(ptr, 1'b1, rx, ack);
        check_bit("ptr ack", ack, 1'b0);
        for (int k = 0; k < 3; k++) begin
            dat[k] = rng_reg[15:8];
            i2cs_master_model_inst.xfer(dat[k], 1'b1, rx, ack);
            check_bit("data ack", ack, k == 2);
        end
        i2cs_master_model_inst.stop();
        check_byte("ptr kept", rd_ptr, ptr + 8'h02);
        stall <= 1'b0;
        repeat (40) @(posedge clk);
        check_byte("words", 8'(q_ptr.size()), 8'h02);
        for (int k = 0; k < 2; k++) begin
            check_byte("word ptr", q_ptr[k], ptr + 8'(k));
            check_byte("word data", q_data[k], dat[k]);
        end
        // pointer wrap, repeated start, then a read with no pointer
        ptr = 8'hff;
        addr_phase(own, 1'b0, ack);
        i2cs_master_model_inst.xfer(ptr, 1'b1, rx, ack);
        addr_phase(own, 1'b1, ack);
        check_bit("sr ack", ack, 1'b0);
        i2cs_master_model_inst.xfer(8'hff, 1'b0, rx, ack);
        check_byte("rd0", rx, reg_val(ptr));
        i2cs_master_model_inst.xfer(8'hff, 1'b1, rx, ack);
        check_byte("rd1", rx, reg_val(ptr + 8'h01));
        i2cs_master_model_inst.stop();
        check_bit("released", sda_oe_n, 1'b1);
        addr_phase(own, 1'b1, ack);
        i2cs_master_model_inst.xfer(8'hff, 1'b1, rx, ack);
        check_byte("reread", rx, reg_val(ptr + 8'h01));
        i2cs_master_model_inst.stop();
        // partial byte cut off by a repeated start
        i2cs_master_model_inst.start();
        for (int k = 0; k < 4; k++) begin
            i2cs_master_model_inst.bit_io(1'b0, ack);
        end
        addr_phase(own, 1'b0, ack);
        check_bit("abort", ack, 1'b0);
        i2cs_master_model_inst.stop();
        for (int k = 1; k < 4; k++) begin
            if_low <= k[0];
            sys_low <= k[1];
            repeat (20) @(posedge clk);
            addr_phase(own, 1'b0, ack);
            check_bit("supply", ack, k == 3);
            i2cs_master_model_inst.stop();
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
